// file: hw/usbsr_regs.sv
// SIE status, address, split and SOF-test register group with the transaction status queue.
// Notes on behaviour
// - Setting the start flag begins a test counting correctly received SOFs.
// - The test ends after the time of 250 SOFs at the current speed.
// - At test end the done flag rises and the count holds good SOFs.
// - The SOF count is read-only and updated only by the test hardware.
// - Device address register is write-only and addresses every transaction.
// - Only the low 7 bits of the written device address are kept.
// - Host mode hub address for split transactions, 7 bits, all groups.
// - Host mode hub port for split transactions, 7 bits, all groups.
// - In device mode only, status words queue 16 deep, in the order transactions occurred.
// - Each status word marks the event flags of its cycle and the endpoint number.
// - Clearing an applicable event flag advances the status queue.
// - Any write to the status register empties the whole queue.
// - Without no-retry, clearing the timeout flag leaves the queue alone.
// - Status bit 10 marks a received LPM transaction.
// - With no-retry set, status bit 9 marks a timed-out transaction.
// - The state register is plain read-write scratch storage.
// - Status bits 8 to 4: illegal NAK, stall, setup, OUT, IN.
// - Status bits 3:0 hold the endpoint; bit 9 is zero without no-retry.
`timescale 1ns/1ps
`include "usbsr_params.svh"

module usbsr_regs
    import usbsr_pkg::*;
#(
    parameter int FS_TEST_CYCLES = `USBSR_FS_TEST_CYCLES, // Full speed test length.
    parameter int HS_TEST_CYCLES = `USBSR_HS_TEST_CYCLES  // High speed test length.
) (
    input  wire logic        clock,           // 250 MHz clock.
    input  wire logic        reset,           // Asynchronous reset, active high.
    input  wire logic [3:0]  reg_addr,        // Register index.
    input  wire logic [15:0] reg_wdata,       // Write data.
    input  wire logic        reg_wr,          // Write strobe.
    input  wire logic        reg_rd,          // Read strobe.
    output logic      [15:0] reg_rdata,       // Read data, cycle after the strobe.
    input  wire logic        host_mode,       // Engine works as host.
    input  wire logic        high_speed,      // Bus runs at high speed.
    input  wire logic        sof_ok,          // Pulse per correctly received SOF.
    input  wire logic        evt_in_sent,     // IN data sent.
    input  wire logic        evt_out_rcvd,    // OUT data received.
    input  wire logic        evt_setup_rcvd,  // SETUP received.
    input  wire logic        evt_stall_sent,  // STALL handshake sent.
    input  wire logic        evt_illegal_nak, // Illegal NAK seen.
    input  wire logic        evt_timeout,     // Transaction timed out.
    input  wire logic        evt_lpm_rcvd,    // LPM transaction received.
    input  wire logic [3:0]  evt_ep,          // Endpoint of the event.
    output logic      [6:0]  device_address,  // Address for all transactions.
    output logic      [6:0]  hub_address,     // Split hub address.
    output logic      [6:0]  hub_port,        // Split hub port.
    output logic             no_retry,        // No-retry-on-timeout flag.
    output logic      [6:0]  event_flags,     // Sticky event flags.
    output logic             sof_test_done    // SOF test complete.
);

    usbsr_word_t      task_state_scratch_reg;
    usbsr_word_t      sof_received_count_reg;
    usbsr_word_t      sof_tally_reg;
    logic [6:0]       device_address_reg;
    logic [6:0]       hub_address_reg;
    logic [6:0]       hub_port_reg;
    logic             no_retry_reg;
    usbsr_flags_t     flags_reg;
    usbsr_flags_t     flags_next;
    logic             done_reg;
    usbsr_sof_state_t sof_state_reg;
    logic [25:0]      sof_timer_reg;
    usbsr_word_t      rdata_reg;
    usbsr_status_t    queue_mem [16];
    logic [3:0]       head_reg;
    logic [3:0]       tail_reg;
    logic [4:0]       level_reg;

    logic             wr_state;
    logic             wr_devaddr;
    logic             wr_hubaddr;
    logic             wr_hubport;
    logic             wr_status;
    logic             wr_ctrl;
    logic             wr_flags;
    logic             start_test;
    usbsr_flags_t     events;
    usbsr_flags_t     pop_mask;
    logic             push;
    logic             pop;
    logic             queue_full;
    logic             queue_empty;
    usbsr_status_t    push_word;
    usbsr_status_t    head_word;
    usbsr_word_t      head_read;
    logic             timer_end;

    assign wr_state   = reg_wr && (reg_addr == `USBSR_OFF_STATE);
    assign wr_devaddr = reg_wr && (reg_addr == `USBSR_OFF_DEVADDR);
    assign wr_hubaddr = reg_wr && (reg_addr == `USBSR_OFF_HUBADDR);
    assign wr_hubport = reg_wr && (reg_addr == `USBSR_OFF_HUBPORT);
    assign wr_status  = reg_wr && (reg_addr == `USBSR_OFF_STATUS);
    assign wr_ctrl    = reg_wr && (reg_addr == `USBSR_OFF_CTRL);
    assign wr_flags   = reg_wr && (reg_addr == `USBSR_OFF_FLAGS);
    assign start_test = wr_ctrl && reg_wdata[`USBSR_CTRL_START];

    assign events[`USBSR_FLG_IN]      = evt_in_sent;
    assign events[`USBSR_FLG_OUT]     = evt_out_rcvd;
    assign events[`USBSR_FLG_SETUP]   = evt_setup_rcvd;
    assign events[`USBSR_FLG_STALL]   = evt_stall_sent;
    assign events[`USBSR_FLG_NAK]     = evt_illegal_nak;
    assign events[`USBSR_FLG_TIMEOUT] = evt_timeout;
    assign events[`USBSR_FLG_LPM]     = evt_lpm_rcvd;

    // Scratch and address registers.

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            task_state_scratch_reg <= `USBSR_RST_WORD;
        end else if (wr_state) begin
            task_state_scratch_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            device_address_reg <= `USBSR_RST_ADDR7;
        end else if (wr_devaddr) begin
            device_address_reg <= reg_wdata[6:0];
        end
    end

    // The split fields are only stored and driven out; the split transaction logic lives elsewhere.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hub_address_reg <= `USBSR_RST_ADDR7;
        end else if (wr_hubaddr) begin
            hub_address_reg <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hub_port_reg <= `USBSR_RST_ADDR7;
        end else if (wr_hubport) begin
            hub_port_reg <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            no_retry_reg <= 1'b0;
        end else if (wr_ctrl) begin
            no_retry_reg <= reg_wdata[`USBSR_CTRL_NORETRY];
        end
    end

    // Sticky event flags; an event in the clearing cycle wins over the clear.

    always_comb begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = flags_next & ~reg_wdata[6:0];
        end
        flags_next = flags_next | events;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flags_reg <= `USBSR_RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // SOF reception test.

    assign timer_end = (sof_state_reg == USBSR_SOF_RUN) && (sof_timer_reg == 26'h0000001);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sof_state_reg <= USBSR_SOF_IDLE;
            sof_timer_reg <= 26'h0000000;
        end else begin
            case (sof_state_reg)
                USBSR_SOF_IDLE: begin
                    if (start_test) begin
                        sof_state_reg <= USBSR_SOF_RUN;
                        sof_timer_reg <= high_speed ? HS_TEST_CYCLES[25:0] : FS_TEST_CYCLES[25:0];
                    end
                end
                USBSR_SOF_RUN: begin
                    if (start_test) begin
                        sof_timer_reg <= high_speed ? HS_TEST_CYCLES[25:0] : FS_TEST_CYCLES[25:0];
                    end else if (timer_end) begin
                        sof_state_reg <= USBSR_SOF_IDLE;
                        sof_timer_reg <= 26'h0000000;
                    end else begin
                        sof_timer_reg <= sof_timer_reg - 26'h0000001;
                    end
                end
                default: begin
                    sof_state_reg <= USBSR_SOF_IDLE;
                end
            endcase
        end
    end

    // The running tally saturates so a chattering source cannot wrap it back to a small number.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sof_tally_reg <= `USBSR_RST_WORD;
        end else if (start_test) begin
            sof_tally_reg <= `USBSR_RST_WORD;
        end else if ((sof_state_reg == USBSR_SOF_RUN) && sof_ok && (sof_tally_reg != 16'hFFFF)) begin
            sof_tally_reg <= sof_tally_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sof_received_count_reg <= `USBSR_RST_WORD;
        end else if (timer_end) begin
            sof_received_count_reg <= (sof_ok && (sof_tally_reg != 16'hFFFF)) ?
                                      sof_tally_reg + 16'h0001 : sof_tally_reg;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            done_reg <= 1'b0;
        end else if (start_test) begin
            // A restart in the last cycle of a run begins a fresh test, so done must not rise.
            done_reg <= 1'b0;
        end else if (timer_end) begin
            done_reg <= 1'b1;
        end else if (wr_flags && reg_wdata[`USBSR_FLAG_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    // Transaction status queue.

    always_comb begin
        push_word = 11'h000;
        push_word[`USBSR_ST_EP_MSB:0] = evt_ep;
        push_word[`USBSR_ST_IN]       = evt_in_sent;
        push_word[`USBSR_ST_OUT]      = evt_out_rcvd;
        push_word[`USBSR_ST_SETUP]    = evt_setup_rcvd;
        push_word[`USBSR_ST_STALL]    = evt_stall_sent;
        push_word[`USBSR_ST_NAK]      = evt_illegal_nak;
        push_word[`USBSR_ST_TIMEOUT]  = evt_timeout && no_retry_reg;
        push_word[`USBSR_ST_LPM]      = evt_lpm_rcvd;
    end

    always_comb begin
        pop_mask = 7'h7F;
        pop_mask[`USBSR_FLG_TIMEOUT] = no_retry_reg;
    end

    assign queue_full  = (level_reg == 5'h10);
    assign queue_empty = (level_reg == 5'h00);
    assign head_word   = queue_mem[head_reg];
    // The timeout bit is gated again at read time, so a word queued before no-retry was cleared reads it as zero.
    assign head_read   = {5'h00, head_word[`USBSR_ST_LPM], head_word[`USBSR_ST_TIMEOUT] && no_retry_reg,
                          head_word[`USBSR_ST_NAK:0]};
    // A timeout without no-retry is retried by the engine, so it is not a queued event.
    assign push = !host_mode && ((events & pop_mask) != 7'h00) && !queue_full;
    assign pop  = wr_flags && ((reg_wdata[6:0] & flags_reg & pop_mask) != 7'h00) && !queue_empty;

    always_ff @(posedge clock) begin
        if (push) begin
            queue_mem[tail_reg] <= push_word;
        end
    end

    // A flush outranks a push in the same cycle, so a bus reset leaves nothing stale behind.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            head_reg  <= 4'h0;
            tail_reg  <= 4'h0;
            level_reg <= 5'h00;
        end else if (wr_status) begin
            head_reg  <= 4'h0;
            tail_reg  <= 4'h0;
            level_reg <= 5'h00;
        end else begin
            if (push) begin
                tail_reg <= tail_reg + 4'h1;
            end
            if (pop) begin
                head_reg <= head_reg + 4'h1;
            end
            if (push && !pop) begin
                level_reg <= level_reg + 5'h01;
            end else if (pop && !push) begin
                level_reg <= level_reg - 5'h01;
            end
        end
    end

    // Read port.

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_reg <= `USBSR_RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                `USBSR_OFF_STATE:   rdata_reg <= task_state_scratch_reg;
                `USBSR_OFF_SOFCNT:  rdata_reg <= sof_received_count_reg;
                `USBSR_OFF_HUBADDR: rdata_reg <= {9'h000, hub_address_reg};
                `USBSR_OFF_HUBPORT: rdata_reg <= {9'h000, hub_port_reg};
                `USBSR_OFF_STATUS:  rdata_reg <= queue_empty ? 16'h0000 : head_read;
                `USBSR_OFF_CTRL:    rdata_reg <= {13'h0000, (sof_state_reg == USBSR_SOF_RUN), no_retry_reg, 1'b0};
                `USBSR_OFF_FLAGS:   rdata_reg <= {8'h00, done_reg, flags_reg};
                `USBSR_OFF_LEVEL:   rdata_reg <= {11'h000, level_reg};
                default:            rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign reg_rdata      = rdata_reg;
    assign device_address = device_address_reg;
    assign hub_address    = hub_address_reg;
    assign hub_port       = hub_port_reg;
    assign no_retry       = no_retry_reg;
    assign event_flags    = flags_reg;
    assign sof_test_done  = done_reg;

    // Checks.

    a_addr_low_bits: assert property (@(posedge clock) disable iff (reset)
        wr_devaddr |=> device_address == $past(reg_wdata[6:0]))
        else $error("device address not the low seven written bits");

    a_addr_write_only: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `USBSR_OFF_DEVADDR |=> reg_rdata == 16'h0000)
        else $error("device address register readable");

    a_hub_fields: assert property (@(posedge clock) disable iff (reset)
        wr_hubaddr |=> hub_address == $past(reg_wdata[6:0]) ##1 $stable(hub_address) || $past(wr_hubaddr))
        else $error("hub address not kept");

    a_port_field: assert property (@(posedge clock) disable iff (reset)
        wr_hubport |=> hub_port == $past(reg_wdata[6:0]))
        else $error("hub port not kept");

    a_flush_empty: assert property (@(posedge clock) disable iff (reset)
        wr_status |=> level_reg == 5'h00 && head_reg == tail_reg)
        else $error("status queue not emptied by write");

    a_push_level: assert property (@(posedge clock) disable iff (reset)
        push && !pop && !wr_status |=> level_reg == $past(level_reg) + 5'h01)
        else $error("queue level did not grow on push");

    a_timeout_hold: assert property (@(posedge clock) disable iff (reset)
        wr_flags && !no_retry_reg && reg_wdata[6:0] == 7'h20 && !push |=> level_reg == $past(level_reg))
        else $error("timeout clear moved the queue");

    a_pop_level: assert property (@(posedge clock) disable iff (reset)
        pop && !push && !wr_status |=> level_reg == $past(level_reg) - 5'h01)
        else $error("queue did not advance on flag clear");

    a_empty_read: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `USBSR_OFF_STATUS && queue_empty |=> reg_rdata == 16'h0000)
        else $error("empty queue read not zero");

    a_bit9_gate: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `USBSR_OFF_STATUS && !no_retry_reg |=> !reg_rdata[`USBSR_ST_TIMEOUT])
        else $error("timeout bit set without no-retry");

    a_test_done: assert property (@(posedge clock) disable iff (reset)
        timer_end && !start_test |=> sof_test_done && sof_state_reg == USBSR_SOF_IDLE)
        else $error("SOF test end did not raise done");

    a_count_ro: assert property (@(posedge clock) disable iff (reset)
        !$past(timer_end) |-> $stable(sof_received_count_reg))
        else $error("SOF count changed outside test end");

    a_start_run: assert property (@(posedge clock) disable iff (reset)
        start_test |=> sof_state_reg == USBSR_SOF_RUN && !sof_test_done && sof_tally_reg == 16'h0000)
        else $error("SOF test did not start");

endmodule : usbsr_regs

// file: hw/usbsr_params.svh
// Register offsets, field positions, reset values and timing counts of the SIE status group.
`ifndef USBSR_PARAMS_SVH
`define USBSR_PARAMS_SVH

`define USBSR_OFF_STATE      4'h0
`define USBSR_OFF_SOFCNT     4'h1
`define USBSR_OFF_DEVADDR    4'h2
`define USBSR_OFF_HUBADDR    4'h3
`define USBSR_OFF_HUBPORT    4'h4
`define USBSR_OFF_STATUS     4'h5
`define USBSR_OFF_CTRL       4'h6
`define USBSR_OFF_FLAGS      4'h7
`define USBSR_OFF_LEVEL      4'h8

`define USBSR_CTRL_START     0
`define USBSR_CTRL_NORETRY   1
`define USBSR_CTRL_RUNNING   2
`define USBSR_FLAG_DONE      7

`define USBSR_FLG_IN         0
`define USBSR_FLG_OUT        1
`define USBSR_FLG_SETUP      2
`define USBSR_FLG_STALL      3
`define USBSR_FLG_NAK        4
`define USBSR_FLG_TIMEOUT    5
`define USBSR_FLG_LPM        6

`define USBSR_ST_EP_MSB      3
`define USBSR_ST_IN          4
`define USBSR_ST_OUT         5
`define USBSR_ST_SETUP       6
`define USBSR_ST_STALL       7
`define USBSR_ST_NAK         8
`define USBSR_ST_TIMEOUT     9
`define USBSR_ST_LPM         10

`define USBSR_RST_WORD       16'h0000
`define USBSR_RST_ADDR7      7'h00
`define USBSR_RST_FLAGS      7'h00

`define USBSR_CLK_PERIOD_NS  4
`define USBSR_SOF_TEST_COUNT 250
`define USBSR_FS_FRAME_NS    1000000
`define USBSR_HS_FRAME_NS    125000
`define USBSR_FS_TEST_CYCLES (`USBSR_SOF_TEST_COUNT * `USBSR_FS_FRAME_NS / `USBSR_CLK_PERIOD_NS)
`define USBSR_HS_TEST_CYCLES (`USBSR_SOF_TEST_COUNT * `USBSR_HS_FRAME_NS / `USBSR_CLK_PERIOD_NS)

`endif

// file: hw/usbsr_pkg.sv
// Types shared by the SIE status register group.
package usbsr_pkg;

    typedef enum logic {
        USBSR_SOF_IDLE,
        USBSR_SOF_RUN
    } usbsr_sof_state_t;

    typedef logic [15:0] usbsr_word_t;
    typedef logic [10:0] usbsr_status_t;
    typedef logic [6:0]  usbsr_flags_t;

endpackage : usbsr_pkg

// file: sim/usbsr_bus_model.sv
// Behavioural USB bus partner that produces good-SOF and transaction event pulses.
`timescale 1ns/1ps

module usbsr_bus_model (
    input  wire logic       clock,  // Bench clock.
    output logic            sof_ok, // Good SOF pulse.
    output logic      [6:0] evt,    // Event pulses in flag order.
    output logic      [3:0] evt_ep  // Event endpoint.
);
    initial begin
        sof_ok = 1'b0;
        evt    = 7'h00;
        evt_ep = 4'hA;
    end

    task automatic send_event(input logic [6:0] mask, input logic [3:0] ep);
        @(posedge clock);
        evt    <= mask;
        evt_ep <= ep;
        @(posedge clock);
        evt    <= 7'h00;
        // The endpoint lines mean nothing between events, so they must not keep the old value.
        evt_ep <= ~ep;
        // Return off the edge, so a caller looking at the flags sees them settled.
        #1;
    endtask : send_event

    task automatic send_sofs(input int n);
        repeat (n) begin
            @(posedge clock);
            sof_ok <= 1'b1;
            @(posedge clock);
            sof_ok <= 1'b0;
        end
    endtask : send_sofs
endmodule : usbsr_bus_model

// file: sim/usbsr_regs_tb.sv
// Self-checking bench for the SIE status, address and SOF-test register group.
`timescale 1ns/1ps
`include "usbsr_params.svh"

module usbsr_regs_tb;
    import usbsr_pkg::*;
    localparam int FS = 50;
    localparam int HS = 20;

    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        host_mode = 1'b0;
    logic        high_speed = 1'b0;
    logic        sof_ok;
    logic [6:0]  evt;
    logic [3:0]  evt_ep;
    logic [6:0]  device_address;
    logic [6:0]  hub_address;
    logic [6:0]  hub_port;
    logic        no_retry;
    logic [6:0]  event_flags;
    logic        sof_test_done;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          n;

    always #2 clock = ~clock;

    usbsr_bus_model i_bus (.clock(clock), .sof_ok(sof_ok), .evt(evt), .evt_ep(evt_ep));

    usbsr_regs #(.FS_TEST_CYCLES(FS), .HS_TEST_CYCLES(HS)) i_dut (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_mode(host_mode),
        .high_speed(high_speed), .sof_ok(sof_ok), .evt_in_sent(evt[0]), .evt_out_rcvd(evt[1]),
        .evt_setup_rcvd(evt[2]), .evt_stall_sent(evt[3]), .evt_illegal_nak(evt[4]),
        .evt_timeout(evt[5]), .evt_lpm_rcvd(evt[6]), .evt_ep(evt_ep),
        .device_address(device_address), .hub_address(hub_address), .hub_port(hub_port),
        .no_retry(no_retry), .event_flags(event_flags), .sof_test_done(sof_test_done));

    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input usbsr_word_t exp, input usbsr_word_t got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic chk_rd(input string name, input logic [3:0] a, input usbsr_word_t exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask : chk_rd

    // A bounded wait, so a test that never completes ends the run instead of hanging it.
    task automatic wait_done(output int cycles);
        cycles = 0;
        while (sof_test_done !== 1'b1) begin
            if (cycles > 1000) begin
                error_cnt++;
                end_of_test();
            end
            @(posedge clock);
            #1;
            cycles++;
        end
    endtask : wait_done

    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        chk_rd("state", `USBSR_OFF_STATE, 16'h0000);
        chk_rd("sofcnt", `USBSR_OFF_SOFCNT, 16'h0000);
        chk_rd("status", `USBSR_OFF_STATUS, 16'h0000);
        wr(`USBSR_OFF_STATE, 16'hA5C3);
        chk_rd("state", `USBSR_OFF_STATE, 16'hA5C3);
        wr(`USBSR_OFF_DEVADDR, 16'hFFAB);
        chk("device_address", 16'h002B, {9'h000, device_address});
        chk_rd("devaddr", `USBSR_OFF_DEVADDR, 16'h0000);
        wr(`USBSR_OFF_HUBADDR, 16'hFFFF);
        wr(`USBSR_OFF_HUBPORT, 16'hFF85);
        chk("hub_address", 16'h007F, {9'h000, hub_address});
        chk_rd("hubaddr", `USBSR_OFF_HUBADDR, 16'h007F);
        chk("hub_port", 16'h0005, {9'h000, hub_port});
        chk_rd("hubport", `USBSR_OFF_HUBPORT, 16'h0005);
        wr(4'hF, 16'h1234);
        chk_rd("unmapped", 4'hF, 16'h0000);
        host_mode <= 1'b1;
        i_bus.send_event(7'h01, 4'h1);
        host_mode <= 1'b0;
        chk_rd("level", `USBSR_OFF_LEVEL, 16'h0000);
        i_bus.send_event(7'h20, 4'h7);
        for (int i = 0; i < 7; i++) if (i != 5) i_bus.send_event(7'(1 << i), 4'(i + 1));
        chk("event_flags", 16'h007F, {9'h000, event_flags});
        chk_rd("level", `USBSR_OFF_LEVEL, 16'h0006);
        chk_rd("status", `USBSR_OFF_STATUS, 16'h0011);
        chk_rd("status", `USBSR_OFF_STATUS, 16'h0011);
        wr(`USBSR_OFF_FLAGS, 16'h0020);
        chk_rd("level", `USBSR_OFF_LEVEL, 16'h0006);
        for (int i = 0; i < 7; i++) if (i != 5) begin
            chk_rd("status", `USBSR_OFF_STATUS, 16'(1 << (i + 4)) | 16'(i + 1));
            wr(`USBSR_OFF_FLAGS, 16'(1 << i));
        end
        chk_rd("status", `USBSR_OFF_STATUS, 16'h0000);
        wr(`USBSR_OFF_CTRL, 16'h0002);
        chk("no_retry", 16'h0001, {15'h0000, no_retry});
        i_bus.send_event(7'h20, 4'h3);
        for (int k = 0; k < 16; k++) i_bus.send_event(7'h01, 4'(k));
        chk_rd("level", `USBSR_OFF_LEVEL, 16'h0010);
        chk_rd("status", `USBSR_OFF_STATUS, 16'h0203);
        wr(`USBSR_OFF_FLAGS, 16'h0020);
        chk_rd("status", `USBSR_OFF_STATUS, 16'h0010);
        chk_rd("level", `USBSR_OFF_LEVEL, 16'h000F);
        wr(`USBSR_OFF_STATUS, 16'h0000);
        chk_rd("level", `USBSR_OFF_LEVEL, 16'h0000);
        for (int hs = 0; hs < 2; hs++) begin
            high_speed <= hs[0];
            wr(`USBSR_OFF_CTRL, 16'h0001);
            chk("done_cleared", 16'h0000, {15'h0000, sof_test_done});
            fork
                i_bus.send_sofs(hs ? 3 : 7);
                wait_done(n);
            join
            chk("test_cycles", 16'(hs ? HS : FS), 16'(n));
            chk_rd("sofcnt", `USBSR_OFF_SOFCNT, 16'(hs ? 3 : 7));
        end
        wr(`USBSR_OFF_SOFCNT, 16'hFFFF);
        i_bus.send_sofs(2);
        chk_rd("sofcnt", `USBSR_OFF_SOFCNT, 16'h0003);
        wr(`USBSR_OFF_CTRL, 16'h0003);
        chk_rd("ctrl", `USBSR_OFF_CTRL, 16'h0006);
        end_of_test();
    end
endmodule : usbsr_regs_tb
